/* File: pkg/isol_pkg.sv */
// Constants and types shared by the inverter status output logic
package isol_pkg;

  // ==========================================================================
  // Function selector codes
  // ==========================================================================
  localparam logic [4:0] ISOL_SEL_PID_DEV = 5'h04;
  localparam logic [4:0] ISOL_SEL_FAULT = 5'h05;
  localparam logic [4:0] ISOL_SEL_TORQUE = 5'h07;
  localparam logic [4:0] ISOL_SEL_BRK_REL = 5'h13;
  localparam logic [4:0] ISOL_SEL_BRK_FLT = 5'h14;
  localparam logic [4:0] ISOL_SEL_ZERO_SPD = 5'h15;
  localparam logic [4:0] ISOL_SEL_NONE = 5'h1F;

  // Control characteristic codes that select vector control
  localparam logic [2:0] ISOL_CC_SLV = 3'h3;
  localparam logic [2:0] ISOL_CC_SLV_0HZ = 3'h4;
  localparam logic [2:0] ISOL_CC_ENC_VEC = 3'h5;

  // ==========================================================================
  // Default and maximum parameter values (tenths of percent, hundredths of Hz)
  // ==========================================================================
  localparam logic [15:0] ISOL_PID_THR_DEF = 16'h001E;
  localparam logic [15:0] ISOL_PID_THR_MAX = 16'h03E8;
  localparam logic [15:0] ISOL_ZS_THR_DEF = 16'h0000;
  localparam logic [15:0] ISOL_ZS_THR_MAX = 16'h2710;
  localparam logic [15:0] ISOL_TQ_THR_DEF = 16'h03E8;
  localparam logic [15:0] ISOL_TQ_THR_MAX = 16'h07D0;

  // Fault number reported for a brake fault
  localparam logic [7:0] ISOL_BRAKE_FAULT_CODE = 8'h24;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int ISOL_CLK_HZ = 10_000_000;
  localparam int ISOL_FAULT_DELAY_MS = 300;
  localparam int ISOL_FAULT_DELAY_CYC = ISOL_FAULT_DELAY_MS * (ISOL_CLK_HZ / 1000);
  localparam int ISOL_MS_CYC = ISOL_CLK_HZ / 1000;

  // Brake supervision states
  typedef enum logic [1:0] {
    ISOL_BRK_IDLE = 2'b00,
    ISOL_BRK_ACCEL = 2'b01,
    ISOL_BRK_DECEL = 2'b10,
    ISOL_BRK_FAULT = 2'b11
  } isol_brk_state_t;

endpackage

/* File: core/isol_out_mux.sv */
// Selector multiplexer that maps a function code onto one output
module isol_out_mux
  import isol_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // Selector and internal status signals
  input wire logic [4:0] i_sel,
  input wire logic i_pid_dev,
  input wire logic i_fault,
  input wire logic i_torque,
  input wire logic i_brk_rel,
  input wire logic i_brk_flt,
  input wire logic i_zero_spd,
  // Registered output level
  output logic o_out
);

  logic out_d;

  // Pick one status by code; unknown codes drive inactive
  always_comb begin
    case (i_sel)
      ISOL_SEL_PID_DEV: out_d = i_pid_dev;
      ISOL_SEL_FAULT: out_d = i_fault;
      ISOL_SEL_TORQUE: out_d = i_torque;
      ISOL_SEL_BRK_REL: out_d = i_brk_rel;
      ISOL_SEL_BRK_FLT: out_d = i_brk_flt;
      ISOL_SEL_ZERO_SPD: out_d = i_zero_spd;
      default: out_d = 1'b0;
    endcase
  end

  // Output flip-flop
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      o_out <= 1'b0;
    end else begin
      o_out <= out_d;
    end
  end

endmodule

/* File: core/isol_status_out.sv */
// Status output logic of a motor inverter: supervision functions and output routing
//
// Summary of operation
// - Deviation flag high while setpoint-actual difference exceeds threshold.
// - Deviation checked only with PID active; threshold 0..100 %, default 3.0.
// - Selector code 04 routes the deviation flag to that output.
// - Selector code 05 routes the fault alarm, active while a fault stands.
// - By default the fault alarm goes to the main signal relay.
// - Fault alarm follows a fault after about 300 ms.
// - After supply loss fault alarm holds until DC bus drops below cut-off.
// - Selector code 19 routes the brake release signal.
// - Selector code 20 routes the brake fault signal.
// - Accelerating: brake fault if confirm still inactive at timeout.
// - Decelerating: brake fault if confirm still active at timeout.
// - Brake fault if release wait expires before enable current reached.
// - A brake fault reports the brake fault code as the active fault.
// - Any fault disables motor drive; the motor is not actively stopped.
// - Zero speed flag while frequency below threshold; 0..100 Hz, default 0.
// - Selector code 21 routes the zero speed flag.
// - Torque flag when torque reaches threshold of the current quadrant.
// - Torque flag only in the three vector modes, inactive otherwise.
// - Selector code 07 routes the torque exceeded flag.
// - By default the torque flag goes to digital output 14.
// - Control characteristic 03, 04, 05 are the vector modes.
module isol_status_out
  import isol_pkg::*;
#(
  parameter int FAULT_DELAY_CYC = ISOL_FAULT_DELAY_CYC,
  parameter int MS_CYC = ISOL_MS_CYC,
  parameter int N_OUT = 5
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // PID supervision
  input wire logic i_pid_active,
  input wire logic [15:0] i_pid_setpoint,
  input wire logic [15:0] i_pid_actual,
  input wire logic [15:0] i_pid_deviation_threshold,
  // Fault state and supply
  input wire logic i_fault_active,
  input wire logic [7:0] i_fault_code,
  input wire logic i_supply_ok,
  input wire logic i_dc_bus_above_cutoff,
  // Brake control
  input wire logic i_brake_release_req,
  input wire logic i_accel,
  input wire logic i_decel,
  input wire logic i_brake_confirm,
  input wire logic [15:0] i_brake_confirm_timeout,
  input wire logic [15:0] i_brake_release_wait,
  input wire logic [15:0] i_motor_current,
  input wire logic [15:0] i_brake_enable_current,
  // Speed and torque
  input wire logic [15:0] i_actual_freq,
  input wire logic [15:0] i_zero_speed_threshold,
  input wire logic [2:0] i_control_characteristic,
  input wire logic [15:0] i_torque,
  input wire logic i_torque_ccw,
  input wire logic i_torque_regen,
  input wire logic [15:0] i_torque_thr_cw_drive,
  input wire logic [15:0] i_torque_thr_ccw_drive,
  input wire logic [15:0] i_torque_thr_cw_regen,
  input wire logic [15:0] i_torque_thr_ccw_regen,
  // Output selectors, a high level on the strap picks the defaults
  input wire logic i_use_defaults,
  input wire logic [4:0] i_output_selector [N_OUT],
  input wire logic [4:0] i_relay_selector,
  // Routed outputs
  output logic [N_OUT-1:0] o_dig_out,
  output logic o_relay_out,
  // Status
  output logic o_pid_deviation_flag,
  output logic o_fault_alarm,
  output logic o_brake_release,
  output logic o_brake_fault,
  output logic o_zero_speed_flag,
  output logic o_torque_exceeded_flag,
  output logic [7:0] o_active_fault_code,
  output logic o_drive_enable
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Absolute difference of two unsigned values
  function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
    abs_diff = (a > b) ? 16'(a - b) : 16'(b - a);
  endfunction

  // Clamp a threshold to its documented maximum
  function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] mx);
    clamp = (v > mx) ? mx : v;
  endfunction

  localparam int FD_W = $clog2(FAULT_DELAY_CYC + 1);
  localparam int MS_W = $clog2(MS_CYC + 1);

  // ==========================================================================
  // PID deviation
  // ==========================================================================
  logic pid_dev_q;

  // Flag follows the comparison while PID control runs
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      pid_dev_q <= 1'b0;
    end else begin
      pid_dev_q <= i_pid_active &&
                   (abs_diff(i_pid_setpoint, i_pid_actual) >
                    clamp(i_pid_deviation_threshold, ISOL_PID_THR_MAX));
    end
  end

  // ==========================================================================
  // Brake supervision
  // ==========================================================================
  isol_brk_state_t brk_state_q;
  logic [MS_W-1:0] ms_cnt_q;
  logic ms_tick;
  logic [15:0] confirm_ms_q;
  logic [15:0] wait_ms_q;
  logic brk_fault_q;
  logic brk_rel_q;
  logic cur_ok_q;

  assign ms_tick = (ms_cnt_q == MS_W'(MS_CYC - 1));

  // Millisecond enable divider
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      ms_cnt_q <= '0;
    end else if (ms_tick) begin
      ms_cnt_q <= '0;
    end else begin
      ms_cnt_q <= ms_cnt_q + 1'b1;
    end
  end

  // Supervision state machine with confirm timer
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      brk_state_q <= ISOL_BRK_IDLE;
      confirm_ms_q <= '0;
    end else begin
      case (brk_state_q)
        ISOL_BRK_IDLE: begin
          confirm_ms_q <= '0;
          if (i_accel) begin
            brk_state_q <= ISOL_BRK_ACCEL;
          end else if (i_decel) begin
            brk_state_q <= ISOL_BRK_DECEL;
          end
        end
        ISOL_BRK_ACCEL: begin
          if (i_brake_confirm) begin
            brk_state_q <= ISOL_BRK_IDLE;
          end else if (ms_tick && confirm_ms_q >= i_brake_confirm_timeout) begin
            brk_state_q <= ISOL_BRK_FAULT;
          end else if (ms_tick) begin
            confirm_ms_q <= confirm_ms_q + 1'b1;
          end
        end
        ISOL_BRK_DECEL: begin
          if (!i_brake_confirm) begin
            brk_state_q <= ISOL_BRK_IDLE;
          end else if (ms_tick && confirm_ms_q >= i_brake_confirm_timeout) begin
            brk_state_q <= ISOL_BRK_FAULT;
          end else if (ms_tick) begin
            confirm_ms_q <= confirm_ms_q + 1'b1;
          end
        end
        default: begin
          if (!i_accel && !i_decel && !i_brake_release_req) begin
            brk_state_q <= ISOL_BRK_IDLE;
          end
        end
      endcase
    end
  end

  // Release wait timer against the brake enable current
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      wait_ms_q <= '0;
      cur_ok_q <= 1'b0;
    end else if (!i_brake_release_req) begin
      wait_ms_q <= '0;
      cur_ok_q <= 1'b0;
    end else begin
      if (i_motor_current >= i_brake_enable_current) begin
        cur_ok_q <= 1'b1;
      end
      if (ms_tick && wait_ms_q != 16'hFFFF) begin
        wait_ms_q <= wait_ms_q + 1'b1;
      end
    end
  end

  // Brake fault and release outputs
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      brk_fault_q <= 1'b0;
      brk_rel_q <= 1'b0;
    end else begin
      brk_fault_q <= (brk_state_q == ISOL_BRK_FAULT) ||
                     (i_brake_release_req && !cur_ok_q &&
                      wait_ms_q >= i_brake_release_wait);
      brk_rel_q <= i_brake_release_req && !brk_fault_q;
    end
  end

  // ==========================================================================
  // Fault alarm, fault code and drive enable
  // ==========================================================================
  logic fault_any;
  logic [FD_W-1:0] fault_cnt_q;
  logic alarm_q;
  logic [7:0] code_q;
  logic drv_en_q;

  assign fault_any = i_fault_active || brk_fault_q;

  // Delay from fault to alarm; hold after supply loss until bus drops
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      fault_cnt_q <= '0;
      alarm_q <= 1'b0;
    end else if (!i_supply_ok) begin
      alarm_q <= alarm_q && i_dc_bus_above_cutoff;
    end else if (!fault_any) begin
      fault_cnt_q <= '0;
      alarm_q <= 1'b0;
    end else if (fault_cnt_q >= FD_W'(FAULT_DELAY_CYC - 1)) begin
      alarm_q <= 1'b1;
    end else begin
      fault_cnt_q <= fault_cnt_q + 1'b1;
    end
  end

  // Active fault code and drive inhibit
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      code_q <= 8'h00;
      drv_en_q <= 1'b0;
    end else begin
      if (brk_fault_q) begin
        code_q <= ISOL_BRAKE_FAULT_CODE;
      end else if (i_fault_active) begin
        code_q <= i_fault_code;
      end else begin
        code_q <= 8'h00;
      end
      drv_en_q <= !fault_any;
    end
  end

  // ==========================================================================
  // Zero speed and torque
  // ==========================================================================
  logic zs_q;
  logic tq_q;
  logic vec_mode;
  logic [15:0] tq_thr;

  assign vec_mode = (i_control_characteristic == ISOL_CC_SLV) ||
                    (i_control_characteristic == ISOL_CC_SLV_0HZ) ||
                    (i_control_characteristic == ISOL_CC_ENC_VEC);

  // Threshold of the present quadrant
  always_comb begin
    case ({i_torque_ccw, i_torque_regen})
      2'b00: tq_thr = i_torque_thr_cw_drive;
      2'b01: tq_thr = i_torque_thr_cw_regen;
      2'b10: tq_thr = i_torque_thr_ccw_drive;
      default: tq_thr = i_torque_thr_ccw_regen;
    endcase
  end

  // Comparisons
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      zs_q <= 1'b0;
      tq_q <= 1'b0;
    end else begin
      zs_q <= i_actual_freq < clamp(i_zero_speed_threshold, ISOL_ZS_THR_MAX);
      tq_q <= vec_mode &&
              (i_torque >= clamp(tq_thr, ISOL_TQ_THR_MAX));
    end
  end

  // ==========================================================================
  // Output routing
  // ==========================================================================
  logic [4:0] sel [N_OUT+1];

  // Defaults: torque on output 14, fault alarm on the relay, others unused
  always_comb begin
    for (int k = 0; k < N_OUT; k++) begin
      if (i_use_defaults) begin
        sel[k] = (k == 3) ? ISOL_SEL_TORQUE : ISOL_SEL_NONE;
      end else begin
        sel[k] = i_output_selector[k];
      end
    end
    sel[N_OUT] = i_use_defaults ? ISOL_SEL_FAULT : i_relay_selector;
  end

  for (genvar g = 0; g <= N_OUT; g++) begin : g_mux
    logic mux_out;
    isol_out_mux u_mux (
      .i_mclk(i_mclk),
      .i_rstn(i_rstn),
      .i_sel(sel[g]),
      .i_pid_dev(pid_dev_q),
      .i_fault(alarm_q),
      .i_torque(tq_q),
      .i_brk_rel(brk_rel_q),
      .i_brk_flt(brk_fault_q),
      .i_zero_spd(zs_q),
      .o_out(mux_out)
    );
    if (g < N_OUT) begin : g_dig
      assign o_dig_out[g] = mux_out;
    end else begin : g_rel
      assign o_relay_out = mux_out;
    end
  end

  // Status outputs straight from flip-flops
  assign o_pid_deviation_flag = pid_dev_q;
  assign o_fault_alarm = alarm_q;
  assign o_brake_release = brk_rel_q;
  assign o_brake_fault = brk_fault_q;
  assign o_zero_speed_flag = zs_q;
  assign o_torque_exceeded_flag = tq_q;
  assign o_active_fault_code = code_q;
  assign o_drive_enable = drv_en_q;

endmodule

/* File: sim/isol_status_out_props.sv */
// Assertion checker for the inverter status output logic
module isol_status_out_props
  import isol_pkg::*;
#(
  parameter int FAULT_DELAY_CYC = 20,
  parameter int N_OUT = 5
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // Watched inputs
  input wire logic i_pid_active,
  input wire logic [15:0] i_pid_setpoint,
  input wire logic [15:0] i_pid_actual,
  input wire logic [15:0] i_pid_deviation_threshold,
  input wire logic i_fault_active,
  input wire logic i_supply_ok,
  input wire logic i_dc_bus_above_cutoff,
  input wire logic [15:0] i_actual_freq,
  input wire logic [15:0] i_zero_speed_threshold,
  input wire logic [2:0] i_control_characteristic,
  input wire logic i_use_defaults,
  input wire logic [4:0] i_output_selector [N_OUT],
  input wire logic [4:0] i_relay_selector,
  // Watched outputs
  input wire logic [N_OUT-1:0] o_dig_out,
  input wire logic o_relay_out,
  input wire logic o_pid_deviation_flag,
  input wire logic o_fault_alarm,
  input wire logic o_brake_fault,
  input wire logic o_zero_speed_flag,
  input wire logic o_torque_exceeded_flag,
  input wire logic [7:0] o_active_fault_code,
  input wire logic o_drive_enable
);
  localparam int LO = FAULT_DELAY_CYC - 9;
  localparam int HI = FAULT_DELAY_CYC + 3;
  logic [15:0] pid_dev;
  logic vec_mode;
  // Absolute deviation and vector mode decode
  assign pid_dev = (i_pid_setpoint > i_pid_actual) ? i_pid_setpoint - i_pid_actual : i_pid_actual - i_pid_setpoint;
  assign vec_mode = i_control_characteristic inside {ISOL_CC_SLV, ISOL_CC_SLV_0HZ, ISOL_CC_ENC_VEC};
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  // ==========================================================================
  // Properties
  // ==========================================================================
  sequence s_alarm_quiet; !o_fault_alarm [*8]; endsequence
  property p_pid_flag; i_pid_active && pid_dev > i_pid_deviation_threshold |=> o_pid_deviation_flag; endproperty
  property p_pid_idle; !i_pid_active |=> !o_pid_deviation_flag; endproperty
  property p_zero_spd; i_actual_freq < i_zero_speed_threshold |=> o_zero_speed_flag; endproperty
  property p_tq_mode; !vec_mode |=> !o_torque_exceeded_flag; endproperty
  property p_route_pid;
    o_pid_deviation_flag && !i_use_defaults && i_relay_selector == ISOL_SEL_PID_DEV |=> o_relay_out;
  endproperty
  property p_route_none; !i_use_defaults && i_output_selector[4] == ISOL_SEL_NONE |=> !o_dig_out[4]; endproperty
  property p_defaults;
    i_use_defaults |=> o_dig_out[3] == $past(o_torque_exceeded_flag) && o_relay_out == $past(o_fault_alarm);
  endproperty
  property p_fault_delay;
    $rose(i_fault_active) && !o_fault_alarm && i_supply_ok |-> s_alarm_quiet ##[LO:HI] o_fault_alarm;
  endproperty
  property p_loss_hold; o_fault_alarm && !i_supply_ok && i_dc_bus_above_cutoff |=> o_fault_alarm; endproperty
  property p_drive_off; i_fault_active |-> ##[1:2] !o_drive_enable; endproperty
  property p_brk_code; $rose(o_brake_fault) |=> o_active_fault_code == ISOL_BRAKE_FAULT_CODE; endproperty
  a_pid_flag: assert property (p_pid_flag) else $error("deviation flag missing");
  a_pid_idle: assert property (p_pid_idle) else $error("deviation flag without control");
  a_zero_spd: assert property (p_zero_spd) else $error("zero speed flag missing");
  a_tq_mode: assert property (p_tq_mode) else $error("torque flag outside vector mode");
  a_route_pid: assert property (p_route_pid) else $error("relay misses deviation flag");
  a_route_none: assert property (p_route_none) else $error("unused output driven");
  a_defaults: assert property (p_defaults) else $error("default routing wrong");
  a_fault_delay: assert property (p_fault_delay) else $error("alarm delay wrong");
  a_loss_hold: assert property (p_loss_hold) else $error("alarm dropped early");
  a_drive_off: assert property (p_drive_off) else $error("drive kept enabled");
  a_brk_code: assert property (p_brk_code) else $error("brake fault code missing");
endmodule

bind isol_status_out isol_status_out_props #(.FAULT_DELAY_CYC(FAULT_DELAY_CYC), .N_OUT(N_OUT)) u_props (
  .i_mclk, .i_rstn, .i_pid_active, .i_pid_setpoint, .i_pid_actual, .i_pid_deviation_threshold,
  .i_fault_active, .i_supply_ok, .i_dc_bus_above_cutoff, .i_actual_freq, .i_zero_speed_threshold,
  .i_control_characteristic, .i_use_defaults, .i_output_selector, .i_relay_selector, .o_dig_out,
  .o_relay_out, .o_pid_deviation_flag, .o_fault_alarm, .o_brake_fault, .o_zero_speed_flag,
  .o_torque_exceeded_flag, .o_active_fault_code, .o_drive_enable
);

/* File: sim/isol_brake_model.sv */
// Behavioural external brake answering the release command with a confirm contact
module isol_brake_model (
  // Clock
  input wire logic i_mclk,
  // Release command and behaviour controls
  input wire logic i_release,
  input wire logic i_stuck,
  input wire logic i_slow,
  // Confirm contact
  output logic o_confirm
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] lag_q = 4'h0;
  initial o_confirm = 1'b0;
  // Confirm follows release after a mechanical lag, unless the contact sticks
  always @(posedge i_mclk) begin
    lag_q <= (i_release == o_confirm) ? 4'h0 : lag_q + 4'h1;
    if (!i_stuck && lag_q == (i_slow ? 4'hC : 4'h1)) o_confirm <= i_release;
  end
endmodule

/* File: sim/testbench.sv */
// Self-checking testbench for the inverter status output logic
module testbench
  import isol_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int FDC = 20;
  // Design inputs with power-on values
  logic i_mclk = 1'b0, i_rstn = 1'b0, i_pid_active = 1'b0, i_fault_active = 1'b0, i_supply_ok = 1'b1;
  logic i_dc_bus_above_cutoff = 1'b1, i_brake_release_req = 1'b0, i_accel = 1'b0, i_decel = 1'b0, i_brake_confirm;
  logic i_torque_ccw = 1'b0, i_torque_regen = 1'b0, i_use_defaults = 1'b0, i_stuck = 1'b0, i_slow = 1'b0;
  logic [15:0] i_pid_setpoint = 16'h0000, i_pid_actual = 16'h0000, i_pid_deviation_threshold = 16'h001E;
  logic [15:0] i_brake_confirm_timeout = 16'h000A, i_brake_release_wait = 16'h0005, i_motor_current = 16'h0100;
  logic [15:0] i_brake_enable_current = 16'h0080, i_actual_freq = 16'h0000, i_zero_speed_threshold = 16'h0000;
  logic [15:0] i_torque = 16'h0000, i_torque_thr_cw_drive = 16'h03E8, i_torque_thr_ccw_drive = 16'h03E8;
  logic [15:0] i_torque_thr_cw_regen = 16'h03E8, i_torque_thr_ccw_regen = 16'h03E8;
  logic [7:0] i_fault_code = 8'h0B;
  logic [2:0] i_control_characteristic = 3'h0;
  logic [4:0] i_relay_selector = 5'h1F;
  logic [4:0] i_output_selector [5] = '{5'h13, 5'h14, 5'h05, 5'h07, 5'h1F};
  // Design outputs and counters
  logic [4:0] o_dig_out;
  logic o_relay_out, o_pid_deviation_flag, o_fault_alarm, o_brake_release, o_brake_fault;
  logic o_zero_speed_flag, o_torque_exceeded_flag, o_drive_enable;
  logic [7:0] o_active_fault_code;
  int fails = 0;
  int total_checks = 0;
  // ==========================================================================
  // Design, brake and clock
  // ==========================================================================
  isol_status_out #(.FAULT_DELAY_CYC(FDC), .MS_CYC(4), .N_OUT(5)) dut (
    .i_mclk, .i_rstn, .i_pid_active, .i_pid_setpoint, .i_pid_actual, .i_pid_deviation_threshold,
    .i_fault_active, .i_fault_code, .i_supply_ok, .i_dc_bus_above_cutoff, .i_brake_release_req,
    .i_accel, .i_decel, .i_brake_confirm, .i_brake_confirm_timeout, .i_brake_release_wait,
    .i_motor_current, .i_brake_enable_current, .i_actual_freq, .i_zero_speed_threshold,
    .i_control_characteristic, .i_torque, .i_torque_ccw, .i_torque_regen, .i_torque_thr_cw_drive,
    .i_torque_thr_ccw_drive, .i_torque_thr_cw_regen, .i_torque_thr_ccw_regen, .i_use_defaults,
    .i_output_selector, .i_relay_selector, .o_dig_out, .o_relay_out, .o_pid_deviation_flag,
    .o_fault_alarm, .o_brake_release, .o_brake_fault, .o_zero_speed_flag, .o_torque_exceeded_flag,
    .o_active_fault_code, .o_drive_enable
  );
  isol_brake_model brake (.i_mclk, .i_release(o_brake_release), .i_stuck, .i_slow, .o_confirm(i_brake_confirm));
  always #50 i_mclk = ~i_mclk;
  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic chk(logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic settle(int n);
    repeat (n) @(posedge i_mclk);
    @(negedge i_mclk);
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Bounded wait for alarm (sel high) or brake fault
  task automatic wait_hi(logic sel, int lim, output int n);
    for (n = 0; n < lim && (sel ? o_fault_alarm : o_brake_fault) !== 1'b1; n++) settle(0);
    if (n == lim) begin
      fails++;
      tally_and_finish();
    end
  endtask
  // One brake fault cause, its report, then clearing
  task automatic brk_case(logic [2:0] ads, logic stuck, logic [15:0] cur, int lo);
    int n;
    @(posedge i_mclk);
    {i_accel, i_decel, i_brake_release_req} <= ads;
    i_stuck <= stuck;
    i_motor_current <= cur;
    wait_hi(1'b0, 120, n);
    chk(n >= lo, 1);
    settle(2);
    chk({o_active_fault_code, o_dig_out[1:0], o_drive_enable}, {ISOL_BRAKE_FAULT_CODE, 3'h4});
    @(posedge i_mclk);
    {i_accel, i_decel, i_brake_release_req, i_stuck} <= 4'h0;
    i_motor_current <= 16'h0100;
    settle(30);
    chk(o_brake_fault, 0);
  endtask
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_reset();
    settle(0);
    chk({o_dig_out, o_relay_out, o_drive_enable, o_brake_fault}, 16'h0000);
    @(posedge i_mclk);
    i_rstn <= 1'b1;
    settle(3);
    chk({o_drive_enable, o_zero_speed_flag, o_active_fault_code}, 16'h0200);
  endtask
  task automatic t_mux();
    logic [4:0] codes [6] = '{5'h04, 5'h15, 5'h07, 5'h01, 5'h1F, 5'h13};
    logic [0:5] exp = 6'h30;
    logic [15:0] pa [3] = '{16'h01E2, 16'h01E1, 16'h0100};
    @(posedge i_mclk);
    {i_pid_active, i_pid_setpoint, i_pid_actual} <= {1'b1, 16'h0200, 16'h0100};
    i_zero_speed_threshold <= 16'h0064;
    for (int k = 0; k < 6; k++) begin
      @(posedge i_mclk);
      i_output_selector[4] <= codes[k];
      i_relay_selector <= codes[k];
      settle(3);
      chk({o_dig_out[4], o_relay_out}, {2{exp[k]}});
    end
    for (int k = 0; k < 3; k++) begin
      @(posedge i_mclk);
      i_pid_actual <= pa[k];
      i_pid_active <= (k < 2);
      settle(2);
      chk(o_pid_deviation_flag, k == 1);
    end
    @(posedge i_mclk);
    i_actual_freq <= 16'h0064;
    settle(2);
    chk(o_zero_speed_flag, 0);
  endtask
  task automatic t_torque();
    logic [63:0] tv;
    @(posedge i_mclk);
    i_torque <= 16'h0400;
    for (int m = 0; m < 6; m++) begin
      @(posedge i_mclk);
      i_control_characteristic <= m[2:0];
      settle(2);
      chk(o_torque_exceeded_flag, m >= 3);
    end
    for (int q = 0; q < 8; q++) begin
      tv = {4{16'h07D0}};
      tv[q[1:0]*16 +: 16] = 16'h0400;
      @(posedge i_mclk);
      {i_torque_thr_ccw_regen, i_torque_thr_cw_regen, i_torque_thr_ccw_drive, i_torque_thr_cw_drive} <= tv;
      {i_torque_regen, i_torque_ccw} <= q[1:0];
      i_torque <= q[2] ? 16'h03FF : 16'h0400;
      settle(2);
      chk(o_torque_exceeded_flag, !q[2]);
    end
    @(posedge i_mclk);
    i_torque <= 16'h0400;
    i_use_defaults <= 1'b1;
    settle(3);
    chk({o_dig_out, o_relay_out}, 16'h0010);
    @(posedge i_mclk);
    {i_use_defaults, i_control_characteristic, i_torque} <= 20'h0_0000;
  endtask
  task automatic t_fault();
    int n;
    @(posedge i_mclk);
    i_use_defaults <= 1'b1;
    i_fault_active <= 1'b1;
    wait_hi(1'b1, 60, n);
    chk(n >= FDC - 1 && n <= FDC + 3, 1);
    chk({o_drive_enable, o_active_fault_code}, 16'h000B);
    settle(1);
    chk(o_relay_out, 1);
    @(posedge i_mclk);
    {i_use_defaults, i_supply_ok, i_fault_active} <= 3'h0;
    settle(4);
    chk({o_dig_out[2], o_fault_alarm}, 16'h0003);
    @(posedge i_mclk);
    i_dc_bus_above_cutoff <= 1'b0;
    settle(3);
    chk(o_fault_alarm, 0);
    @(posedge i_mclk);
    {i_supply_ok, i_dc_bus_above_cutoff} <= 2'h3;
  endtask
  task automatic t_brake();
    @(posedge i_mclk);
    {i_slow, i_accel, i_brake_release_req} <= 3'h7;
    settle(80);
    chk({o_dig_out[1:0], i_brake_confirm}, 16'h0003);
    brk_case(3'h2, 1'b1, 16'h0100, 36);
    brk_case(3'h5, 1'b1, 16'h0100, 36);
    brk_case(3'h1, 1'b0, 16'h0010, 16);
  endtask
  // Main sequence
  initial begin
    repeat (15) @(posedge i_mclk);
    t_reset();
    t_mux();
    t_torque();
    t_fault();
    t_brake();
    tally_and_finish();
  end
endmodule
